// file: eip_defs.vh
// Constants for the extended interrupt priority/enable block.
// Assumes byte-wide SFR access with an 8-bit SFR page register.
`ifndef EIP_DEFS_VH
`define EIP_DEFS_VH

`define EIP_ADDR_ENABLE_TWO     8'hE7
`define EIP_ADDR_PRIORITY_ONE   8'hF6
`define EIP_ADDR_PRIORITY_TWO   8'hF7
`define EIP_ADDR_CONFIG         8'hE4
`define EIP_ADDR_TIMER_CTRL     8'h88

`define EIP_PAGE_ZERO           8'h00
`define EIP_PAGE_F              8'h0F

`define EIP_RST_BYTE            8'h00
`define EIP_TWO_MASK            8'h07

`define EIP_CFG_ONE_POL         7
`define EIP_CFG_ONE_SEL_HI      6
`define EIP_CFG_ONE_SEL_LO      4
`define EIP_CFG_ZERO_POL        3
`define EIP_CFG_ZERO_SEL_HI     2
`define EIP_CFG_ZERO_SEL_LO     0

`define EIP_TIMER_CONTROL_REG_ZERO_EDGE      0
`define EIP_TIMER_CONTROL_REG_ZERO_PEND      1
`define EIP_TIMER_CONTROL_REG_ONE_EDGE       2
`define EIP_TIMER_CONTROL_REG_ONE_PEND       3

`endif

// file: eip_ext_input.v
// One external interrupt input: pin select, synchroniser, pending flag.
// Assumes port pins are asynchronous to clk_i.
`timescale 1ns/10ps
`include "eip_defs.vh"

module eip_ext_input (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] port_pins_i,
    input  wire [2:0] pin_select_i,
    input  wire       polarity_i,
    input  wire       edge_select_i,
    input  wire       vector_ack_i,
    input  wire       sw_write_i,
    input  wire       sw_value_i,
    output reg        pending_o
);
    reg [2:0] sync;
    reg       stable;
    wire      active;
    wire      next_stable;

    // Sampled read-only; the crossbar path to the pin is untouched [RULE_08]
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], port_pins_i[pin_select_i]}; // [RULE_15]
        end
    end

    // Accept a change only once stages two and three agree
    assign next_stable = (sync[1] == sync[2]) ? sync[2] : stable;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable <= 1'b0;
        end else begin
            stable <= next_stable;
        end
    end

    assign active = ~(next_stable ^ polarity_i); // [RULE_06]

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_o <= 1'b0;
        end else if (!edge_select_i) begin
            // Level mode follows the input; request persists while active
            pending_o <= active; // [RULE_07] [RULE_12] [RULE_14]
        end else if (active && (stable ^ next_stable)) begin
            // New edge beats a same-cycle clear [RULE_17]
            pending_o <= 1'b1;
        end else if (vector_ack_i) begin
            pending_o <= 1'b0; // [RULE_11]
        end else if (sw_write_i) begin
            pending_o <= sw_value_i;
        end
    end
endmodule

// file: eip_irq_ctrl.v
// Extended priority/enable registers and the two external interrupts.
// Assumes a byte SFR bus with one-cycle read/write strobes and page.
`timescale 1ns/10ps
`include "eip_defs.vh"

// Contract
// RULE_01 - Priority one: one high/low priority bit per peripheral source.
// RULE_02 - Enable two: bits 2:0 mask port match, CAN, dropout.
// RULE_03 - Priority two: bits 2:0 priority of port match, CAN, dropout.
// RULE_04 - Bits 7:3 of enable/priority two read zero, ignore writes.
// RULE_05 - Priority registers only on pages 0x00/0x0F; enable two all.
// RULE_06 - Polarity bit: 0 active low, 1 active high.
// RULE_07 - Type bit: 1 edge sensitive, 0 level sensitive.
// RULE_08 - Pin sampled regardless of crossbar, without disturbing it.
// RULE_09 - Software sets crossbar skip bit for interrupt-only pins.
// RULE_10 - Pending flags at timer control bits 1 and 3.
// RULE_11 - Edge mode pending cleared when processor vectors.
// RULE_12 - Level mode pending follows active input.
// RULE_13 - Level source holds input until request recognised.
// RULE_14 - Level source releases before routine ends, else re-request.
// RULE_15 - Pin select 000..111 picks port 1 pin 0..7.
// RULE_16 - Config byte: pol1, sel1[6:4], pol0, sel0[2:0]; reset zero.
// RULE_17 - Edge mode sets pending on inactive-to-active synced transition.
// RULE_18 - All enable and priority bits reset to zero.
// RULE_19 - Enabled high-priority sources take precedence over low ones.
module eip_irq_ctrl (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] sfr_addr_i,
    input  wire [7:0] sfr_page_i,
    input  wire [7:0] sfr_wdata_i,
    input  wire       sfr_wr_i,
    input  wire       sfr_rd_i,
    input  wire [7:0] port_one_pins_i,
    input  wire [7:0] periph_req_i,
    input  wire [2:0] periph_two_req_i,
    input  wire [1:0] vector_ack_i,
    output reg  [7:0] sfr_rdata_o,
    output reg        sfr_hit_o,
    output reg  [7:0] high_req_o,
    output reg  [7:0] low_req_o,
    output reg  [2:0] high_two_req_o,
    output reg  [2:0] low_two_req_o,
    output reg  [1:0] ext_pending_o,
    output reg  [1:0] ext_polarity_o,
    output reg  [1:0] ext_edge_select_o,
    output reg  [7:0] ext_irq_config_o,
    output reg  [7:0] ext_irq_enable_two_o,
    output reg  [7:0] ext_irq_priority_one_o,
    output reg  [7:0] ext_irq_priority_two_o
);
    reg  [7:0] ext_irq_priority_one;
    reg  [2:0] ext_irq_enable_two;
    reg  [2:0] ext_irq_priority_two;
    reg  [7:0] ext_irq_config_reg;
    reg  [1:0] edge_select;
    wire [1:0] pending;
    wire       prio_page;
    wire       wr_prio_one;
    wire       wr_prio_two;
    wire       wr_en_two;
    wire       wr_cfg;
    wire       wr_timer_control_reg;
    reg  [7:0] next_rdata;
    reg        next_hit;
    reg  [7:0] timer_control_reg_view;
    wire [7:0] en_one_req;
    wire [2:0] en_two_req;

    assign prio_page = (sfr_page_i == `EIP_PAGE_ZERO) ||
                       (sfr_page_i == `EIP_PAGE_F); // [RULE_05]
    assign wr_prio_one = sfr_wr_i && prio_page &&
                         (sfr_addr_i == `EIP_ADDR_PRIORITY_ONE);
    assign wr_prio_two = sfr_wr_i && prio_page &&
                         (sfr_addr_i == `EIP_ADDR_PRIORITY_TWO);
    assign wr_en_two = sfr_wr_i &&
                       (sfr_addr_i == `EIP_ADDR_ENABLE_TWO); // [RULE_05]
    assign wr_cfg = sfr_wr_i && (sfr_page_i == `EIP_PAGE_F) &&
                    (sfr_addr_i == `EIP_ADDR_CONFIG);
    assign wr_timer_control_reg = sfr_wr_i && (sfr_addr_i == `EIP_ADDR_TIMER_CTRL);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_irq_priority_one <= `EIP_RST_BYTE;       // [RULE_18]
            ext_irq_enable_two   <= 3'h0;                // [RULE_18]
            ext_irq_priority_two <= 3'h0;                // [RULE_18]
            ext_irq_config_reg   <= `EIP_RST_BYTE;       // [RULE_16]
            edge_select          <= 2'h0;
        end else begin
            if (wr_prio_one) begin
                ext_irq_priority_one <= sfr_wdata_i;     // [RULE_01]
            end
            if (wr_en_two) begin
                // Upper bits dropped on write [RULE_04]
                ext_irq_enable_two <= sfr_wdata_i[2:0];  // [RULE_02]
            end
            if (wr_prio_two) begin
                ext_irq_priority_two <= sfr_wdata_i[2:0]; // [RULE_03]
            end
            if (wr_cfg) begin
                ext_irq_config_reg <= sfr_wdata_i;       // [RULE_16]
            end
            if (wr_timer_control_reg) begin
                edge_select[0] <= sfr_wdata_i[`EIP_TIMER_CONTROL_REG_ZERO_EDGE];
                edge_select[1] <= sfr_wdata_i[`EIP_TIMER_CONTROL_REG_ONE_EDGE];
            end
        end
    end

    // Instance zero
    eip_ext_input u_ext_zero (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .port_pins_i   (port_one_pins_i),
        .pin_select_i  (ext_irq_config_reg[`EIP_CFG_ZERO_SEL_HI:
                                           `EIP_CFG_ZERO_SEL_LO]),
        .polarity_i    (ext_irq_config_reg[`EIP_CFG_ZERO_POL]),
        .edge_select_i (edge_select[0]),
        .vector_ack_i  (vector_ack_i[0]),
        .sw_write_i    (wr_timer_control_reg),
        .sw_value_i    (sfr_wdata_i[`EIP_TIMER_CONTROL_REG_ZERO_PEND]),
        .pending_o     (pending[0])
    );

    eip_ext_input u_ext_one (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .port_pins_i   (port_one_pins_i),
        .pin_select_i  (ext_irq_config_reg[`EIP_CFG_ONE_SEL_HI:
                                           `EIP_CFG_ONE_SEL_LO]),
        .polarity_i    (ext_irq_config_reg[`EIP_CFG_ONE_POL]),
        .edge_select_i (edge_select[1]),
        .vector_ack_i  (vector_ack_i[1]),
        .sw_write_i    (wr_timer_control_reg),
        .sw_value_i    (sfr_wdata_i[`EIP_TIMER_CONTROL_REG_ONE_PEND]),
        .pending_o     (pending[1])
    );

    // Only the bits this block owns are shown; timer bits read zero
    always @* begin
        timer_control_reg_view = 8'h00;
        timer_control_reg_view[`EIP_TIMER_CONTROL_REG_ZERO_EDGE] = edge_select[0];
        timer_control_reg_view[`EIP_TIMER_CONTROL_REG_ZERO_PEND] = pending[0];     // [RULE_10]
        timer_control_reg_view[`EIP_TIMER_CONTROL_REG_ONE_EDGE]  = edge_select[1];
        timer_control_reg_view[`EIP_TIMER_CONTROL_REG_ONE_PEND]  = pending[1];     // [RULE_10]
    end

    always @* begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                `EIP_ADDR_ENABLE_TWO: begin
                    next_rdata = {5'h00, ext_irq_enable_two}; // [RULE_04]
                    next_hit   = 1'b1;
                end
                `EIP_ADDR_PRIORITY_ONE: begin
                    if (prio_page) begin
                        next_rdata = ext_irq_priority_one;
                        next_hit   = 1'b1;
                    end
                end
                `EIP_ADDR_PRIORITY_TWO: begin
                    if (prio_page) begin
                        next_rdata = {5'h00, ext_irq_priority_two};
                        next_hit   = 1'b1;
                    end
                end
                `EIP_ADDR_CONFIG: begin
                    if (sfr_page_i == `EIP_PAGE_F) begin
                        next_rdata = ext_irq_config_reg;
                        next_hit   = 1'b1;
                    end
                end
                `EIP_ADDR_TIMER_CTRL: begin
                    next_rdata = timer_control_reg_view;
                    next_hit   = 1'b1;
                end
                default: begin
                    next_rdata = 8'h00;
                    next_hit   = 1'b0;
                end
            endcase
        end
    end

    assign en_one_req = periph_req_i;
    assign en_two_req = periph_two_req_i & ext_irq_enable_two; // [RULE_02]

    // Split by level so the vectoring logic serves high before low
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o            <= 8'h00;
            sfr_hit_o              <= 1'b0;
            high_req_o             <= 8'h00;
            low_req_o              <= 8'h00;
            high_two_req_o         <= 3'h0;
            low_two_req_o          <= 3'h0;
            ext_pending_o          <= 2'h0;
            ext_polarity_o         <= 2'h0;
            ext_edge_select_o      <= 2'h0;
            ext_irq_config_o       <= 8'h00;
            ext_irq_enable_two_o   <= 8'h00;
            ext_irq_priority_one_o <= 8'h00;
            ext_irq_priority_two_o <= 8'h00;
        end else begin
            sfr_rdata_o    <= next_rdata;
            sfr_hit_o      <= next_hit;
            high_req_o     <= en_one_req & ext_irq_priority_one;  // [RULE_19]
            low_req_o      <= en_one_req & ~ext_irq_priority_one;
            high_two_req_o <= en_two_req & ext_irq_priority_two;  // [RULE_19]
            low_two_req_o  <= en_two_req & ~ext_irq_priority_two;
            ext_pending_o  <= pending;
            ext_polarity_o <= {ext_irq_config_reg[`EIP_CFG_ONE_POL],
                               ext_irq_config_reg[`EIP_CFG_ZERO_POL]};
            ext_edge_select_o      <= edge_select;
            ext_irq_config_o       <= ext_irq_config_reg;
            ext_irq_enable_two_o   <= {5'h00, ext_irq_enable_two};
            ext_irq_priority_one_o <= ext_irq_priority_one;
            ext_irq_priority_two_o <= {5'h00, ext_irq_priority_two};
        end
    end
endmodule

// file: eip_irq_ctrl_props.sv
// Port checker for the extended priority/enable block.
// Assumes one clock and the byte SFR strobes of the top module.
`timescale 1ns/10ps

module eip_irq_ctrl_props (
    input logic       clk_i,
    input logic       rst_n_i,
    input logic [7:0] sfr_addr_i,
    input logic [7:0] sfr_page_i,
    input logic [7:0] sfr_wdata_i,
    input logic       sfr_wr_i,
    input logic       sfr_rd_i,
    input logic [7:0] port_one_pins_i,
    input logic [7:0] periph_req_i,
    input logic [2:0] periph_two_req_i,
    input logic [1:0] vector_ack_i,
    input logic [7:0] sfr_rdata_o,
    input logic       sfr_hit_o,
    input logic [7:0] high_req_o,
    input logic [7:0] low_req_o,
    input logic [2:0] high_two_req_o,
    input logic [2:0] low_two_req_o,
    input logic [1:0] ext_pending_o,
    input logic [1:0] ext_polarity_o,
    input logic [1:0] ext_edge_select_o,
    input logic [7:0] ext_irq_config_o,
    input logic [7:0] ext_irq_enable_two_o,
    input logic [7:0] ext_irq_priority_one_o,
    input logic [7:0] ext_irq_priority_two_o
);
    wire pg_ok = sfr_page_i == 8'h00 || sfr_page_i == 8'h0F;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_RD_ENABLE: assert property (
        sfr_rd_i && sfr_addr_i == 8'hE7 |=>
        sfr_hit_o && sfr_rdata_o == ext_irq_enable_two_o)
        else $error("enable read wrong");
    AST_EN_WRITE: assert property (
        sfr_wr_i && sfr_addr_i == 8'hE7 |=> ##1
        ext_irq_enable_two_o == ($past(sfr_wdata_i, 2) & 8'h07))
        else $error("enable write wrong");
    AST_PRI_WRITE: assert property (
        sfr_wr_i && sfr_addr_i == 8'hF6 && pg_ok |=> ##1
        ext_irq_priority_one_o == $past(sfr_wdata_i, 2))
        else $error("priority write lost");
    AST_PAGE_GUARD: assert property (
        sfr_wr_i && sfr_addr_i[7:1] == 7'h7B && !pg_ok |=> ##1
        $stable(ext_irq_priority_one_o) && $stable(ext_irq_priority_two_o))
        else $error("foreign page write taken");
    AST_SPLIT_ONE: assert property (
        $past(rst_n_i) |-> high_req_o ==
        ($past(periph_req_i) & ext_irq_priority_one_o) &&
        low_req_o == ($past(periph_req_i) & ~ext_irq_priority_one_o))
        else $error("priority one split wrong");
    AST_SPLIT_TWO: assert property (
        $past(rst_n_i) |-> high_two_req_o == ($past(periph_two_req_i) &
        ext_irq_enable_two_o[2:0] & ext_irq_priority_two_o[2:0]) &&
        low_two_req_o == ($past(periph_two_req_i) &
        ext_irq_enable_two_o[2:0] & ~ext_irq_priority_two_o[2:0]))
        else $error("priority two split wrong");
    AST_POL_VIEW: assert property (
        ext_polarity_o == {ext_irq_config_o[7], ext_irq_config_o[3]})
        else $error("polarity view wrong");
    AST_LEVEL: assert property (
        ($stable(port_one_pins_i) && $stable(ext_irq_config_o) &&
         !ext_edge_select_o[0] && $stable(ext_edge_select_o)) [*8] |->
        ext_pending_o[0] ==
        (port_one_pins_i[ext_irq_config_o[2:0]] == ext_irq_config_o[3]))
        else $error("level pending off");
    AST_ACK_CLEAR: assert property (
        ($stable(port_one_pins_i) && $stable(ext_irq_config_o) &&
         ext_edge_select_o[0] && $stable(ext_edge_select_o)) [*6] ##0
        (vector_ack_i[0] && !sfr_wr_i) |=> ##1 !ext_pending_o[0])
        else $error("pending kept after vector");

    COV_PAGE_READ: cover property (sfr_rd_i && sfr_addr_i == 8'hF7 && pg_ok);
    COV_EDGE_SET: cover property (ext_edge_select_o[0] && ext_pending_o[0]);
    COV_TWO_HIGH: cover property (high_two_req_o != 3'h0);
endmodule

bind eip_irq_ctrl eip_irq_ctrl_props i_eip_irq_ctrl_props (.*);

// file: eip_pin_src.sv
// External interrupt source driving the port pins.
// Assumes the bench keeps the selected pin inactive in base_i.
`timescale 1ns/10ps

module eip_pin_src (
    input  wire       clk_i,
    input  wire [7:0] base_i,
    input  wire [2:0] sel_i,
    input  wire       pol_i,
    input  wire       fire_i,
    input  wire       ack_i,
    output reg  [7:0] pins_o
);
    reg hold = 1'b0;

    // Pin is ours alone, as if the crossbar skips it
    always @(posedge clk_i) begin
        if (fire_i)
            hold <= 1'b1;
        else if (ack_i)
            hold <= 1'b0;
    end

    always @* begin
        pins_o = base_i;
        if (hold)
            pins_o[sel_i] = pol_i;
    end
endmodule

// file: tb_ext_irq_priority_enable.sv
// Bench for the extended priority/enable block and its pin source.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/10ps

module tb_ext_irq_priority_enable;
    reg        clk_i, rst_n_i, wr, rd, fire, pol, n;
    reg  [7:0] addr, page, wdata, preq, base, ra, rp;
    reg  [2:0] preq2, sel;
    reg  [1:0] ack;
    reg  [7:0] mdl [0:255];
    wire [7:0] pins, rdata;
    wire       hit;
    integer    i, seed, n_fail, n_tests;

    eip_pin_src i_eip_pin_src (.clk_i(clk_i), .base_i(base), .sel_i(sel),
        .pol_i(pol), .fire_i(fire), .ack_i(|ack), .pins_o(pins));
    eip_irq_ctrl i_eip_irq_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sfr_addr_i(addr), .sfr_page_i(page), .sfr_wdata_i(wdata),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .port_one_pins_i(pins),
        .periph_req_i(preq), .periph_two_req_i(preq2), .vector_ack_i(ack),
        .sfr_rdata_o(rdata), .sfr_hit_o(hit), .high_req_o(), .low_req_o(),
        .high_two_req_o(), .low_two_req_o(), .ext_pending_o(),
        .ext_polarity_o(), .ext_edge_select_o(), .ext_irq_config_o(),
        .ext_irq_enable_two_o(), .ext_irq_priority_one_o(),
        .ext_irq_priority_two_o());

    // Inputs in level mode mirror their pin; edge pending bits come from the x argument of rd8
    function [7:0] lvl(input [7:0] t, input [7:0] c, input [7:0] p);
        lvl = {4'h0, ~t[2] & (p[c[6:4]] == c[7]), 1'b0,
               ~t[0] & (p[c[2:0]] == c[3]), 1'b0};
    endfunction

    function ok(input [7:0] a, input [7:0] p);
        ok = a == 8'hE7 || a == 8'h88 || (a == 8'hE4 && p == 8'h0F) ||
             (a[7:1] == 7'h7B && (p == 8'h00 || p == 8'h0F));
    endfunction

    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: %h vs %h", $time, got, exp);
            end
        end
    endtask

    task close_out;
        begin
            if (n_fail == 0 && n_tests > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task wr8(input [7:0] a, input [7:0] p, input [7:0] d);
        begin
            @(negedge clk_i);
            {addr, page, wdata, wr} = {a, p, d, 1'b1};
            @(negedge clk_i);
            wr = 1'b0;
            if (ok(a, p))
                mdl[a] = d & ((a == 8'hE7 || a == 8'hF7) ? 8'h07 :
                              (a == 8'h88) ? 8'h05 : 8'hFF);
        end
    endtask

    task rd8(input [7:0] a, input [7:0] p, input [7:0] x);
        begin
            @(negedge clk_i);
            {addr, page, rd} = {a, p, 1'b1};
            @(negedge clk_i);
            rd = 1'b0;
            chk(rdata, (ok(a, p) ? mdl[a] : 8'h00) | x |
                ((a == 8'h88) ? lvl(mdl[8'h88], mdl[8'hE4], pins) :
                 8'h00));
            chk({7'h00, hit}, {7'h00, ok(a, p)});
        end
    endtask

    // Source fires, is recognised, then lets go
    task trip(input [7:0] e);
        begin
            fire = 1'b1;
            @(negedge clk_i);
            fire = 1'b0;
            repeat (8) @(negedge clk_i);
            rd8(8'h88, 8'h00, e);
            ack[n] = 1'b1;
            @(negedge clk_i);
            ack = 2'h0;
            repeat (8) @(negedge clk_i);
            rd8(8'h88, 8'h00, 8'h00);
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        #1000000;
        n_fail = n_fail + 1;
        close_out;
    end

    always @(negedge clk_i) begin
        preq <= 8'($random(seed));
        preq2 <= 3'($random(seed));
    end

    initial begin
        {rst_n_i, wr, rd, fire, pol, n, ack} = 8'h00;
        {addr, page, wdata, base, sel} = 35'h0;
        {seed, n_fail, n_tests} = {32'h7D6EE705, 64'h0};
        for (i = 0; i < 256; i = i + 1)
            mdl[i] = 8'h00;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        rd8(8'hE7, 8'h00, 8'h00);
        rd8(8'hF6, 8'h0F, 8'h00);
        rd8(8'hF7, 8'h00, 8'h00);
        rd8(8'hE4, 8'h0F, 8'h00);
        rd8(8'h55, 8'h00, 8'h00);
        for (i = 0; i < 48; i = i + 1) begin
            ra = (i % 4 == 0) ? 8'hE7 : (i % 4 == 1) ? 8'hF6 :
                 (i % 4 == 2) ? 8'hF7 : 8'hE4;
            rp = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h0F :
                 8'($random(seed));
            wr8(ra, rp, 8'($random(seed)));
            rd8(ra, rp, 8'h00);
        end
        for (i = 0; i < 16; i = i + 1) begin
            {sel, n, pol} = {i[3:1], i[0], i[1]};
            wr8(8'h88, 8'h00, 8'h00);
            base = 8'($random(seed));
            base[sel] = ~pol;
            wr8(8'hE4, 8'h0F, n ? {pol, sel, 4'h0} : {4'h0, pol, sel});
            repeat (8) @(negedge clk_i);
            wr8(8'h88, 8'h00, n ? 8'h04 : 8'h01);
            // Unselected pins move; a wrong select would flag
            base = base ^ ~(8'h01 << sel);
            repeat (8) @(negedge clk_i);
            rd8(8'h88, 8'h00, 8'h00);
            trip(n ? 8'h08 : 8'h02);
            wr8(8'h88, 8'h00, 8'h00);
            trip(n ? 8'h08 : 8'h02);
        end
        close_out;
    end
endmodule
